// File: hw/ccr_regs.sv
// Configuration capability register bank: product data, indirect access, message interrupts, error status
`timescale 1ns/1ns

// Function
// R1: The low byte of the window is the product-data byte at the product-data address, later bytes follow.
// R2: EEPROM accesses go to the product-data address plus 0x40.
// R3: The window register honours each byte enable on writes; reads ignore cfg_be and a write meeting an EEPROM read completion is lost.
// R4: Accesses to the indirect data register go to the internal register chosen by index bits 11:0.
// R5: Message enable low uses the legacy interrupt pin, high uses messages and ignores the pin.
// R6: The requested message count field is read-only power-of-two code, 000 after reset.
// R7: Host software writes the allocated message count with codes 000 to 101 only, reset 000.
// R8: The message capability reads ID 05h and next pointer 00h.
// R9: Message address low is dword aligned, upper address and 16-bit data are writable.
// R10: The error capability ID reads 0001h.
// R11: The error capability version reads 1h.
// R12: The next extended capability offset reads 150h.
// R13: Uncorrectable errors are recorded at their documented bit positions.
// R14: A read operation is started with flag 0 and the device sets the flag when data is ready.
// R15: A write operation is started with flag 1 and the device clears the flag when done.
// R16: Error status bits stay set until a one is written and survive non-power resets.
// R17: With messages enabled an interrupt is a write of the message data to the 64-bit address.
module ccr_regs import ccr_pkg::*; #(
  parameter int IDX_W = IDX_W_DOC,
  parameter logic [2:0] MSG_REQ_CODE = MSG_COUNT_RESET
) (
  // Clock, resets, freeze
  input wire logic clock,
  input wire logic rst,
  input wire logic pwr_rst,
  input wire logic ce,
  // Configuration access
  input wire logic cfg_req,
  input wire logic cfg_wr,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  // EEPROM engine
  output logic ee_req,
  output logic ee_we,
  output logic [EE_AW-1:0] ee_addr,
  output logic [31:0] ee_wdata,
  input wire logic [31:0] ee_rdata,
  input wire logic ee_done,
  // Interrupt delivery
  input wire logic irq_level,
  output logic intx_n,
  output logic msi_req,
  output logic [63:0] msi_addr,
  output logic [MSG_DATA_W-1:0] msi_data,
  input wire logic msi_ack,
  // Error events
  input wire logic [31:0] err_set
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic [9:0] dw;
  logic wr_pd_ctrl, wr_pd_win, wr_idx, wr_idx_data, wr_msg_ctrl;
  logic wr_addr_lo, wr_addr_hi, wr_msg_data, wr_err;
  assign dw = cfg_addr[11:2];
  assign wr_pd_ctrl = cfg_req && cfg_wr && dw == OFF_PD_CTRL[11:2];
  assign wr_pd_win = cfg_req && cfg_wr && dw == OFF_PD_WIN[11:2];
  assign wr_idx = cfg_req && cfg_wr && dw == OFF_IDX[11:2];
  assign wr_idx_data = cfg_req && cfg_wr && dw == OFF_IDX_DATA[11:2];
  assign wr_msg_ctrl = cfg_req && cfg_wr && dw == OFF_MSG_CTRL[11:2];
  assign wr_addr_lo = cfg_req && cfg_wr && dw == OFF_MSG_ADDR_LO[11:2];
  assign wr_addr_hi = cfg_req && cfg_wr && dw == OFF_MSG_ADDR_HI[11:2];
  assign wr_msg_data = cfg_req && cfg_wr && dw == OFF_MSG_DATA[11:2];
  assign wr_err = cfg_req && cfg_wr && dw == OFF_ERR_STAT[11:2];

  // ----------------------------------------
  // Product data control and window
  // ----------------------------------------
  logic [PD_ADDR_W-1:0] pd_addr_r;
  logic pd_flag_r;
  logic [31:0] win_r;
  logic pd_start;
  logic [PD_ADDR_W-1:0] pd_addr_nxt;
  assign pd_start = wr_pd_ctrl && cfg_be[3] && !ee_req;
  assign pd_addr_nxt = cfg_be[2] ? cfg_wdata[PD_ADDR_LSB +: PD_ADDR_W] : pd_addr_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pd_addr_r <= '0;
    end else if (ce && wr_pd_ctrl && !ee_req) begin
      pd_addr_r <= pd_addr_nxt;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pd_flag_r <= 1'b0;
    end else if (ce) begin
      if (pd_start) begin
        pd_flag_r <= cfg_wdata[PD_FLAG_BIT];
      end else if (ee_req && ee_done) begin
        pd_flag_r <= !ee_we; // R14 R15
      end
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      win_r <= '0;
    end else if (ce) begin
      if (ee_req && ee_done && !ee_we) begin
        win_r <= ee_rdata; // R1
      end else if (wr_pd_win) begin
        win_r <= be_merge(win_r, cfg_wdata, cfg_be); // R3
      end
    end
  end
  // EEPROM request held until done
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ee_req <= 1'b0;
      ee_we <= 1'b0;
      ee_addr <= '0;
      ee_wdata <= '0;
    end else if (ce) begin
      if (pd_start) begin
        ee_req <= 1'b1; // R14 R15
        ee_we <= cfg_wdata[PD_FLAG_BIT];
        ee_addr <= {1'b0, pd_addr_nxt, 2'b00} + EE_OFS; // R2
        ee_wdata <= win_r;
      end else if (ee_req && ee_done) begin
        ee_req <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Indirect configuration access
  // ----------------------------------------
  logic [IDX_W-1:0] idx_r;
  logic [31:0] idx_merged;
  logic [31:0] mem_rdata;
  assign idx_merged = be_merge(32'(idx_r), cfg_wdata, cfg_be);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      idx_r <= '0;
    end else if (ce && wr_idx) begin
      idx_r <= idx_merged[IDX_W-1:0];
    end
  end

  ccr_mem #(.AW(IDX_W), .DW(32)) u_mem (
    .clock(clock),
    .ce(ce),
    .we(wr_idx_data), // R4
    .be(cfg_be),
    .addr(idx_r),
    .wdata(cfg_wdata),
    .rdata(mem_rdata)
  );

  // ----------------------------------------
  // Message interrupt registers
  // ----------------------------------------
  logic msg_en_r;
  logic [2:0] msg_alloc_r;
  logic [31:2] addr_lo_r;
  logic [31:0] addr_hi_r;
  logic [MSG_DATA_W-1:0] msg_data_r;
  logic [31:0] alo_m, ahi_m, mdat_m;
  assign alo_m = be_merge({addr_lo_r, 2'b00}, cfg_wdata, cfg_be);
  assign ahi_m = be_merge(addr_hi_r, cfg_wdata, cfg_be);
  assign mdat_m = be_merge(32'(msg_data_r), cfg_wdata, cfg_be);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      msg_en_r <= 1'b0;
      msg_alloc_r <= MSG_COUNT_RESET;
    end else if (ce && wr_msg_ctrl && cfg_be[2]) begin
      msg_en_r <= cfg_wdata[MSG_EN_BIT];
      msg_alloc_r <= cfg_wdata[MSG_ALLOC_LSB +: 3];
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addr_lo_r <= '0;
      addr_hi_r <= '0;
      msg_data_r <= '0;
    end else if (ce) begin
      if (wr_addr_lo) begin
        addr_lo_r <= alo_m[31:2]; // R9
      end
      if (wr_addr_hi) begin
        addr_hi_r <= ahi_m;
      end
      if (wr_msg_data) begin
        msg_data_r <= mdat_m[MSG_DATA_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // Interrupt delivery
  // ----------------------------------------
  logic irq_q_r, pend_r;
  logic irq_rise, msi_issue;
  assign irq_rise = irq_level && !irq_q_r;
  assign msi_issue = !msi_req && msg_en_r && (pend_r || irq_rise);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_q_r <= 1'b0;
      intx_n <= 1'b1;
    end else if (ce) begin
      irq_q_r <= irq_level;
      intx_n <= !(irq_level && !msg_en_r); // R5
    end
  end
  // Event during an issue stays pending
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend_r <= 1'b0;
    end else if (ce) begin
      pend_r <= msg_en_r && ((msi_issue ? 1'b0 : pend_r || irq_rise) || (pend_r && irq_rise));
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      msi_req <= 1'b0;
      msi_addr <= '0;
      msi_data <= '0;
    end else if (ce) begin
      if (msi_issue) begin
        msi_req <= 1'b1; // R17
        msi_addr <= {addr_hi_r, addr_lo_r, 2'b00};
        msi_data <= msg_data_r;
      end else if (msi_req && msi_ack) begin
        msi_req <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Fatal_error_status
  // ----------------------------------------
  logic [31:0] err_r;
  logic [31:0] err_clr;
  assign err_clr = wr_err ? (cfg_wdata & be_mask(cfg_be)) : '0;
  // Reset only by power reset, bits also cleared by writing ones; set wins over clear
  always_ff @(posedge clock or posedge pwr_rst) begin
    if (pwr_rst) begin
      err_r <= '0;
    end else if (ce) begin
      err_r <= ((err_r & ~err_clr) | err_set) & ERR_IMPL; // R13 R16
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic st_vld_r, st_rd_r;
  logic [9:0] st_dw_r;
  logic [31:0] rd_mux;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_vld_r <= 1'b0;
      st_rd_r <= 1'b0;
      st_dw_r <= '0;
    end else if (ce) begin
      st_vld_r <= cfg_req;
      st_rd_r <= cfg_req && !cfg_wr;
      st_dw_r <= dw;
    end
  end

  always_comb begin
    rd_mux = '0;
    case (st_dw_r)
      OFF_PD_CTRL[11:2]: rd_mux = {pd_flag_r, 7'h00, pd_addr_r, 2'b00, PD_NEXT_PTR, PD_CAP_ID};
      OFF_PD_WIN[11:2]: rd_mux = win_r; // R1 R3
      OFF_IDX[11:2]: rd_mux = 32'(idx_r);
      OFF_IDX_DATA[11:2]: rd_mux = mem_rdata; // R4
      OFF_MSG_CTRL[11:2]: rd_mux = {8'h00, MSG_ADDR64_CAP, msg_alloc_r, MSG_REQ_CODE, msg_en_r,
                                    MSG_NEXT_PTR, MSG_CAP_ID}; // R6 R8
      OFF_MSG_ADDR_LO[11:2]: rd_mux = {addr_lo_r, 2'b00}; // R9
      OFF_MSG_ADDR_HI[11:2]: rd_mux = addr_hi_r;
      OFF_MSG_DATA[11:2]: rd_mux = 32'(msg_data_r);
      OFF_ERR_HDR[11:2]: rd_mux = {ERR_NEXT_OFS, ERR_CAP_VER, ERR_CAP_ID}; // R10 R11 R12
      OFF_ERR_STAT[11:2]: rd_mux = err_r; // R13
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_ack <= 1'b0;
      cfg_rdata <= '0;
    end else if (ce) begin
      cfg_ack <= st_vld_r;
      cfg_rdata <= st_rd_r ? rd_mux : '0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_rd(logic [11:0] ofs);
    cfg_req && !cfg_wr && cfg_addr[11:2] == ofs[11:2];
  endsequence
  property p_win_lane;
    @(posedge clock) disable iff (rst || !ce)
    wr_pd_win && cfg_be == 4'h1 && !(ee_req && ee_done) |=>
      win_r[31:8] == $past(win_r[31:8]) && win_r[7:0] == $past(cfg_wdata[7:0]);
  endproperty
  a_win_lane: assert property (p_win_lane) else $error("window lane merge wrong"); // R3
  property p_ee_addr;
    @(posedge clock) disable iff (rst || !ce)
    pd_start |=> ee_req && ee_addr == {1'b0, pd_addr_r, 2'b00} + EE_OFS;
  endproperty
  a_ee_addr: assert property (p_ee_addr) else $error("eeprom address offset wrong"); // R2
  sequence s_rd_done;
    ee_req && !ee_we && ee_done;
  endsequence
  property p_rd_done;
    @(posedge clock) disable iff (rst || !ce)
    s_rd_done |=> pd_flag_r && !ee_req && win_r == $past(ee_rdata);
  endproperty
  a_rd_done: assert property (p_rd_done) else $error("read completion not reported"); // R14
  property p_wr_done;
    @(posedge clock) disable iff (rst || !ce)
    ee_req && ee_we && ee_done |=> !pd_flag_r && !ee_req;
  endproperty
  a_wr_done: assert property (p_wr_done) else $error("write completion not reported"); // R15
  property p_idx_fwd;
    @(posedge clock) disable iff (rst || !ce)
    cfg_req && !cfg_wr && dw == OFF_IDX_DATA[11:2] ##1 (ce && st_rd_r) |->
      ##1 cfg_ack && cfg_rdata == $past(mem_rdata);
  endproperty
  a_idx_fwd: assert property (p_idx_fwd) else $error("indirect read data wrong"); // R4
  property p_intx;
    @(posedge clock) disable iff (rst || !ce)
    msg_en_r [*2] |-> intx_n;
  endproperty
  a_intx: assert property (p_intx) else $error("legacy pin used while messages enabled"); // R5
  sequence s_irq_edge;
    msg_en_r && irq_rise && !msi_req && !pend_r;
  endsequence
  property p_msi;
    @(posedge clock) disable iff (rst || !ce)
    s_irq_edge |=> msi_req && msi_addr == {$past(addr_hi_r), $past(addr_lo_r), 2'b00} &&
      msi_data == $past(msg_data_r);
  endproperty
  a_msi: assert property (p_msi) else $error("message write not issued"); // R17
  property p_msg_cap;
    @(posedge clock) disable iff (rst || !ce)
    s_rd(OFF_MSG_CTRL) |-> ##2 cfg_ack && cfg_rdata[15:0] == {MSG_NEXT_PTR, MSG_CAP_ID} &&
      cfg_rdata[19:17] == MSG_REQ_CODE;
  endproperty
  a_msg_cap: assert property (p_msg_cap) else $error("message capability header wrong"); // R8
  property p_err_hdr;
    @(posedge clock) disable iff (rst || !ce)
    s_rd(OFF_ERR_HDR) |-> ##2 cfg_ack && cfg_rdata == {ERR_NEXT_OFS, ERR_CAP_VER, ERR_CAP_ID};
  endproperty
  a_err_hdr: assert property (p_err_hdr) else $error("error capability header wrong"); // R12
  property p_err_sticky;
    @(posedge clock) disable iff (pwr_rst || !ce)
    !wr_err |=> (err_r & $past(err_r)) == $past(err_r);
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("error status bit lost"); // R16
  property p_err_set;
    @(posedge clock) disable iff (pwr_rst || !ce)
    1'b1 |=> (err_r & $past(err_set & ERR_IMPL)) == $past(err_set & ERR_IMPL);
  endproperty
  a_err_set: assert property (p_err_set) else $error("error event not recorded"); // R13
endmodule

// File: hw/ccr_pkg.sv
// Constants and helpers for the configuration capability register bank
package ccr_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [11:0] OFF_PD_CTRL = 12'h0d8;
  localparam logic [11:0] OFF_PD_WIN = 12'h0dc;
  localparam logic [11:0] OFF_IDX = 12'h0e0;
  localparam logic [11:0] OFF_IDX_DATA = 12'h0e4;
  localparam logic [11:0] OFF_MSG_CTRL = 12'h0f0;
  localparam logic [11:0] OFF_MSG_ADDR_LO = 12'h0f4;
  localparam logic [11:0] OFF_MSG_ADDR_HI = 12'h0f8;
  localparam logic [11:0] OFF_MSG_DATA = 12'h0fc;
  localparam logic [11:0] OFF_ERR_HDR = 12'h100;
  localparam logic [11:0] OFF_ERR_STAT = 12'h104;

  // ----------------------------------------
  // Read-only identity fields
  // ----------------------------------------
  localparam logic [7:0] PD_CAP_ID = 8'h03;
  localparam logic [7:0] PD_NEXT_PTR = 8'hf0;
  localparam logic [7:0] MSG_CAP_ID = 8'h05;
  localparam logic [7:0] MSG_NEXT_PTR = 8'h00;
  localparam logic [2:0] MSG_COUNT_RESET = 3'h0;
  localparam logic MSG_ADDR64_CAP = 1'b1;
  localparam logic [15:0] ERR_CAP_ID = 16'h0001;
  localparam logic [3:0] ERR_CAP_VER = 4'h1;
  localparam logic [11:0] ERR_NEXT_OFS = 12'h150;

  // ----------------------------------------
  // Field positions and widths
  // ----------------------------------------
  localparam int PD_ADDR_LSB = 18;
  localparam int PD_ADDR_W = 6;
  localparam int PD_FLAG_BIT = 31;
  localparam int MSG_EN_BIT = 16;
  localparam int MSG_ALLOC_LSB = 20;
  localparam int MSG_DATA_W = 16;
  localparam int IDX_W_DOC = 12;

  // EEPROM location is product-data address plus a fixed offset
  localparam int EE_AW = 9;
  localparam logic [EE_AW-1:0] EE_OFS = 9'h040;

  // Implemented fatal_error_status bits
  localparam logic [31:0] ERR_IMPL = 32'h001ff011;

  // Byte-enable to bit mask
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Merge written lanes into an old word
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    be_merge = (old & ~be_mask(be)) | (nw & be_mask(be));
  endfunction

endpackage

// File: hw/ccr_mem.sv
// Internal extended configuration storage with byte writes and registered read
`timescale 1ns/1ns

module ccr_mem #(
  parameter int AW = 12,
  parameter int DW = 32
) (
  // Clock and freeze
  input wire logic clock,
  input wire logic ce,
  // Access port
  input wire logic we,
  input wire logic [DW/8-1:0] be,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clock) begin
    if (ce) begin
      for (int i = 0; i < DW/8; i++) begin
        if (we && be[i]) begin
          mem[addr][i*8 +: 8] <= wdata[i*8 +: 8];
        end
      end
      rdata <= mem[addr];
    end
  end

endmodule

// File: test/ccr_far.sv
// Far-side model: serial EEPROM engine and message write acceptor
`timescale 1ns/1ns

module ccr_far import ccr_pkg::*; #(
  parameter int EE_LAT = 20,
  parameter int MSI_LAT = 3
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // EEPROM engine
  input wire logic ee_req,
  input wire logic ee_we,
  input wire logic [EE_AW-1:0] ee_addr,
  input wire logic [31:0] ee_wdata,
  output logic [31:0] ee_rdata,
  output logic ee_done,
  // Message write
  input wire logic msi_req,
  output logic msi_ack
);
  logic [7:0] mem [0:511];
  int ecnt;
  int mcnt;

  initial begin
    for (int i = 0; i < 512; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
  end

  // ----------------------------------------
  // EEPROM: bytes in order from the address
  // ----------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ecnt <= 0;
      ee_done <= 1'b0;
      ee_rdata <= 32'h0;
    end else begin
      ee_done <= 1'b0;
      // Stale data line flips every cycle
      ee_rdata <= ~ee_rdata;
      if (ee_req && !ee_done) begin
        ecnt <= ecnt + 1;
        if (ecnt == EE_LAT) begin
          ecnt <= 0;
          ee_done <= 1'b1;
          if (ee_we) begin
            for (int i = 0; i < 4; i++) begin
              mem[ee_addr + i] <= ee_wdata[8*i +: 8];
            end
          end else begin
            ee_rdata <= {mem[ee_addr + 3], mem[ee_addr + 2], mem[ee_addr + 1], mem[ee_addr]};
          end
        end
      end
    end
  end

  // Message write accepted after a short wait
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      mcnt <= 0;
      msi_ack <= 1'b0;
    end else begin
      msi_ack <= 1'b0;
      if (msi_req && !msi_ack) begin
        mcnt <= mcnt + 1;
        if (mcnt == MSI_LAT) begin
          mcnt <= 0;
          msi_ack <= 1'b1;
        end
      end
    end
  end
endmodule

// File: test/tb.sv
// Testbench for the configuration capability register bank
`timescale 1ns/1ns

module tb import ccr_pkg::*; ;
  logic clock = 0;
  logic rst = 1;
  logic pwr_rst = 1;
  logic ce = 1;
  logic cfg_req = 0;
  logic cfg_wr = 0;
  logic [11:0] cfg_addr = 12'h000;
  logic [3:0] cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0;
  logic [31:0] err_set = 32'h0;
  logic irq_level = 0;
  logic cfg_ack, ee_req, ee_we, ee_done, intx_n, msi_req, msi_ack;
  logic [31:0] cfg_rdata, ee_wdata, ee_rdata, rd;
  logic [EE_AW-1:0] ee_addr;
  logic [63:0] msi_addr;
  logic [MSG_DATA_W-1:0] msi_data;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #2 clock = ~clock;

  ccr_regs uut (.clock(clock), .rst(rst), .pwr_rst(pwr_rst), .ce(ce), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .ee_req(ee_req), .ee_we(ee_we), .ee_addr(ee_addr), .ee_wdata(ee_wdata), .ee_rdata(ee_rdata),
    .ee_done(ee_done), .irq_level(irq_level), .intx_n(intx_n), .msi_req(msi_req), .msi_addr(msi_addr),
    .msi_data(msi_data), .msi_ack(msi_ack), .err_set(err_set));

  ccr_far #(.EE_LAT(20), .MSI_LAT(3)) far (.clock(clock), .rst(rst), .ee_req(ee_req), .ee_we(ee_we),
    .ee_addr(ee_addr), .ee_wdata(ee_wdata), .ee_rdata(ee_rdata), .ee_done(ee_done), .msi_req(msi_req),
    .msi_ack(msi_ack));

  // ----------------------------------------
  // Access and check tasks
  // ----------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One-cycle request, answer exactly two cycles later
  task automatic cfg(input logic wr, input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    int lat;
    lat = 9;
    @(negedge clock);
    {cfg_req, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, wr, a, be, d};
    @(negedge clock);
    cfg_req = 1'b0;
    for (int n = 0; n < 3; n++) begin
      @(negedge clock);
      if (cfg_ack === 1'b1) begin
        rd = cfg_rdata;
        lat = n;
      end
    end
    chk(lat, 0);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    cfg(1'b0, a, 4'hf, 32'h0);
    chk(rd, exp);
  endtask

  task automatic poll(input logic f);
    for (int n = 0; n < 40; n++) begin
      cfg(1'b0, OFF_PD_CTRL, 4'hf, 32'h0);
      if (rd[31] === f) break;
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(negedge clock);
    {rst, pwr_rst} = 2'b00;
    rchk(OFF_MSG_CTRL, 32'h00800005);
    rchk(OFF_ERR_HDR, 32'h15010001);
    rchk(OFF_PD_WIN, 32'h0);
    rchk(OFF_ERR_STAT, 32'h0);
    rchk(12'h0e8, 32'h0);
    // Read-only fields hold; alloc code kept legal
    cfg(1'b1, OFF_MSG_CTRL, 4'hf, 32'hff5effff);
    rchk(OFF_MSG_CTRL, 32'h00d00005);
    cfg(1'b1, OFF_ERR_HDR, 4'hf, 32'hffffffff);
    rchk(OFF_ERR_HDR, 32'h15010001);
    cfg(1'b1, OFF_MSG_ADDR_LO, 4'hf, 32'h1234567b);
    cfg(1'b1, OFF_MSG_ADDR_HI, 4'hf, 32'h9abcdef0);
    cfg(1'b1, OFF_MSG_DATA, 4'hf, 32'hffffbeef);
    rchk(OFF_MSG_ADDR_LO, 32'h12345678);
    rchk(OFF_MSG_ADDR_HI, 32'h9abcdef0);
    rchk(OFF_MSG_DATA, 32'h0000beef);
    // Legacy pin while messages are off, then message write once enabled
    irq_level = 1'b1;
    repeat (3) @(negedge clock);
    chk({intx_n, msi_req}, 2'b00);
    irq_level = 1'b0;
    cfg(1'b1, OFF_MSG_CTRL, 4'h4, 32'h00510000);
    rchk(OFF_MSG_CTRL, 32'h00d10005);
    irq_level = 1'b1;
    for (int n = 0; n < 8 && msi_req !== 1'b1; n++) @(negedge clock);
    chk({intx_n, msi_req}, 2'b11);
    chk(msi_addr, 64'h9abcdef0_12345678);
    chk(msi_data, 16'hbeef);
    irq_level = 1'b0;
    repeat (8) @(negedge clock);
    chk(msi_req, 1'b0);
    // Window lanes
    cfg(1'b1, OFF_PD_WIN, 4'hf, 32'h11223344);
    cfg(1'b1, OFF_PD_WIN, 4'h5, 32'haabbccdd);
    rchk(OFF_PD_WIN, 32'h11bb33dd);
    cfg(1'b1, OFF_PD_WIN, 4'h1, 32'h000000ee);
    rchk(OFF_PD_WIN, 32'h11bb33ee);
    // Indirect access
    cfg(1'b1, OFF_IDX, 4'hf, 32'h00000123);
    cfg(1'b1, OFF_IDX_DATA, 4'hf, 32'h5a5a1234);
    cfg(1'b1, OFF_IDX, 4'hf, 32'h00000a45);
    cfg(1'b1, OFF_IDX_DATA, 4'hf, 32'h0badf00d);
    cfg(1'b1, OFF_IDX, 4'hf, 32'hfffff123);
    rchk(OFF_IDX, 32'h00000123);
    rchk(OFF_IDX_DATA, 32'h5a5a1234);
    cfg(1'b1, OFF_IDX, 4'hf, 32'h00000a45);
    rchk(OFF_IDX_DATA, 32'h0badf00d);
    // EEPROM read, write, read start while write busy refused, read back
    cfg(1'b1, OFF_PD_CTRL, 4'hc, 32'h00140000);
    chk({ee_req, ee_we, ee_addr}, {2'b10, 9'h054});
    poll(1'b1);
    chk(rd, 32'h8014f003);
    rchk(OFF_PD_WIN, 32'h0d0c0f0e);
    cfg(1'b1, OFF_PD_WIN, 4'hf, 32'hcafef00d);
    cfg(1'b1, OFF_PD_CTRL, 4'hc, 32'h801c0000);
    chk({ee_req, ee_we, ee_addr, ee_wdata}, {2'b11, 9'h05c, 32'hcafef00d});
    cfg(1'b1, OFF_PD_CTRL, 4'hc, 32'h00240000);
    rchk(OFF_PD_CTRL, 32'h801cf003);
    poll(1'b0);
    chk(rd, 32'h001cf003);
    cfg(1'b1, OFF_PD_WIN, 4'hf, 32'h0);
    cfg(1'b1, OFF_PD_CTRL, 4'hc, 32'h001c0000);
    poll(1'b1);
    rchk(OFF_PD_WIN, 32'hcafef00d);
    // Error status: sticky, one to clear
    @(negedge clock);
    err_set = 32'hffffffff;
    @(negedge clock);
    err_set = 32'h0;
    rchk(OFF_ERR_STAT, 32'h001ff011);
    rst = 1'b1;
    @(negedge clock);
    rst = 1'b0;
    rchk(OFF_ERR_STAT, 32'h001ff011);
    rchk(OFF_MSG_CTRL, 32'h00800005);
    rchk(OFF_MSG_ADDR_HI, 32'h0);
    // Write offered while frozen must be lost
    ce = 1'b0;
    @(negedge clock);
    {cfg_req, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, 1'b1, OFF_MSG_ADDR_HI, 4'hf, 32'h55aa55aa};
    @(negedge clock);
    {ce, cfg_req} = 2'b10;
    rchk(OFF_MSG_ADDR_HI, 32'h0);
    cfg(1'b1, OFF_ERR_STAT, 4'hf, 32'h00001010);
    rchk(OFF_ERR_STAT, 32'h001fe001);
    cfg(1'b1, OFF_ERR_STAT, 4'hf, 32'h0);
    rchk(OFF_ERR_STAT, 32'h001fe001);
    pwr_rst = 1'b1;
    @(negedge clock);
    pwr_rst = 1'b0;
    rchk(OFF_ERR_STAT, 32'h0);
    tally_and_finish();
  end
endmodule
